// ### pkg/fxc_pkg.sv
package fxc_pkg;

   // ----------------------------------------------------------------
   // Data path geometry
   // ----------------------------------------------------------------
   localparam int DATA_W = 72;
   localparam int ADDR_W = 14;
   localparam int LVL_W = 15;

   // Array depth; fall-through adds the output register as a word
   localparam logic [LVL_W-1:0] DEPTH_STD = 15'h4000;
   localparam logic [LVL_W-1:0] DEPTH_FT = 15'h4001;
   localparam logic [LVL_W-1:0] LVL_ZERO = 15'h0000;
   localparam logic [LVL_W-1:0] LVL_ONE = 15'h0001;
   localparam logic [ADDR_W-1:0] PTR_ZERO = 14'h0000;
   localparam logic [ADDR_W-1:0] PTR_ONE = 14'h0001;
   localparam logic [DATA_W-1:0] DATA_ZERO = 72'h0;

   // ----------------------------------------------------------------
   // Mark spacing the controller must leave, in bytes and words
   // ----------------------------------------------------------------
   localparam int BYTES_PER_WORD = 8;
   localparam int MARK_MIN_BYTES = 128;
   localparam int MARK_MIN_BYTES_DEEP = 256;
   localparam logic [LVL_W-1:0] MARK_MIN_WORDS =
      LVL_W'(MARK_MIN_BYTES / BYTES_PER_WORD);

   // ----------------------------------------------------------------
   // Retransmit sequencing
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FXC_RT_IDLE = 2'b00,
      FXC_RT_SETUP = 2'b01,
      FXC_RT_DONE = 2'b10
   } fxc_rt_state_t;

endpackage

// ### rtl/fxc_flag_unit.sv
`timescale 1ns/1ps
module fxc_flag_unit #(
   parameter bit FULL_SIDE = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Mode
   input wire logic syncMode,
   // Fill level now and after the current edge
   input wire logic [fxc_pkg::LVL_W-1:0] levelQ,
   input wire logic [fxc_pkg::LVL_W-1:0] levelD,
   input wire logic [fxc_pkg::LVL_W-1:0] offset,
   input wire logic [fxc_pkg::LVL_W-1:0] depth,
   // Active-low flag
   output logic flagN
);
   import fxc_pkg::*;

   function automatic logic hit(input logic [LVL_W-1:0] lvl);
      if (FULL_SIDE) begin
         hit = (lvl >= (depth - offset));
      end else begin
         hit = (lvl <= offset);
      end
   endfunction

   logic flagD;

   // ----------------------------------------------------------------
   // Flag update
   // ----------------------------------------------------------------
   // Sync mode looks at the settled level, so it lags one edge behind
   // the freeing access; async mode follows the access at once.
   assign flagD = syncMode ? ~hit(levelQ) : ~hit(levelD);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flagN <= 1'b1;
      end else begin
         flagN <= flagD;
      end
   end

   AST_SYNC_LAG: assert property (@(posedge clk) disable iff (!rstn)
      syncMode && (hit(levelQ) != hit(levelD)) && $stable(offset)
      |=> ##1 (flagN == ~hit($past(levelD, 2))))
      else $error("sync flag did not follow level one edge later");

   AST_ASYNC_NOW: assert property (@(posedge clk) disable iff (!rstn)
      !syncMode && $stable(offset) |=> (flagN == ~hit($past(levelD))))
      else $error("async flag did not follow the access edge");

endmodule

// ### rtl/fxc_fifo_ctrl.sv
// Overview of operation
// - Fall-through loads first word regardless; later reads need both enables low.
// - Synchronous flag mode updates almost-full on every clock edge, from the settled level.
// - Synchronous almost-full deasserts one cycle after the freeing read.
// - Async mode: almost-full low on write event, high on read event.
// - Async mode: almost-empty low on read event, high on write event.
// - Fall-through input-ready goes low one cycle after a freeing read.
// - Fall-through depth is one word larger; flags use that depth.
// - While marked, the write pointer never passes the marked location.
// - Standard mode ends retransmit setup by returning empty indicator high.
// - Standard-mode echo enable is registered AND of enables, forced high when empty.
// - Read bus driven only while chip select and output enable are low.
// - Fall-through echo pulses low on each cycle a new word loads.
// - Fall-through read past last word raises valid flag and echo.
// - Fall-through uses synchronous read timing only.
`timescale 1ns/1ps
module fxc_fifo_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Modes, caught at the first edge after reset release
   input wire logic flagTimingSelect,
   input wire logic fallThroughMode,
   // Flag offsets
   input wire logic [fxc_pkg::LVL_W-1:0] almostEmptyOffset,
   input wire logic [fxc_pkg::LVL_W-1:0] almostFullOffset,
   // Write port
   input wire logic writeEnableN,
   input wire logic [fxc_pkg::DATA_W-1:0] writeData,
   // Read port
   input wire logic readChipSelectN,
   input wire logic readEnableN,
   input wire logic outputEnableN,
   // Mark and retransmit
   input wire logic markReq,
   input wire logic retransmitN,
   // Read data bus, enable low while driven
   output logic [fxc_pkg::DATA_W-1:0] readDataBus,
   output logic readDataOeN,
   // Status
   output logic emptyIndicator,
   output logic fullFlag,
   output logic outputValidFlag,
   output logic inputReadyFlag,
   output logic almostFullFlag,
   output logic almostEmptyFlag,
   output logic echoedReadEnable
);
   import fxc_pkg::*;

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem [0:DEPTH_STD-1];
   logic [ADDR_W-1:0] wrPtr_q, rdPtr_q, markPtr_q;
   logic [ADDR_W-1:0] wrPtr_d, rdPtr_d, markDist;
   logic [LVL_W-1:0] memLevel_q, memLevel_d, totLevel_q, totLevel_d;
   logic [LVL_W-1:0] flagDepth, rtLevel;
   logic [DATA_W-1:0] outReg_q;
   logic outValid_q, outValid_d;
   logic cfgDone_q, ftMode_q, syncFlags_q, markHold_q;
   fxc_rt_state_t rtState_q, rtState_d;

   // ----------------------------------------------------------------
   // Request decoding
   // ----------------------------------------------------------------
   logic rdReq, memEmpty, memFull, markBlock, rtStart, setupBusy;
   logic wrAcc, stdRead, loadOut, rdAcc, markRise;

   assign rdReq = ~readChipSelectN & ~readEnableN;
   assign memEmpty = (memLevel_q == LVL_ZERO);
   assign memFull = (memLevel_q == DEPTH_STD);
   // Write stops at the mark so held data survives a retransmit
   assign markBlock = markHold_q & (wrPtr_q == markPtr_q);
   assign setupBusy = (rtState_q == FXC_RT_SETUP);
   assign rtStart = cfgDone_q & markHold_q & ~retransmitN
      & (rtState_q == FXC_RT_IDLE);
   assign wrAcc = cfgDone_q & ~writeEnableN & ~memFull & ~markBlock;
   // Reads are taken on the clock only; no async read path exists
   assign stdRead = rdReq & ~memEmpty;
   // Empty output register fills on its own; refill needs both enables
   assign loadOut = ~memEmpty & (~outValid_q | rdReq);
   assign rdAcc = cfgDone_q & ~rtStart & ~setupBusy
      & (ftMode_q ? loadOut : stdRead);
   assign markRise = cfgDone_q & markReq & ~markHold_q;

   // ----------------------------------------------------------------
   // Next pointers and levels
   // ----------------------------------------------------------------
   assign wrPtr_d = wrAcc ? wrPtr_q + PTR_ONE : wrPtr_q;
   assign markDist = wrPtr_d - markPtr_q;
   // Equal pointers after a mark mean the array is full, not empty
   assign rtLevel = (markDist == PTR_ZERO) ? DEPTH_STD
      : {1'b0, markDist};
   assign rdPtr_d = rtStart ? markPtr_q
      : (rdAcc ? rdPtr_q + PTR_ONE : rdPtr_q);
   assign memLevel_d = rtStart ? rtLevel
      : memLevel_q + LVL_W'(wrAcc) - LVL_W'(rdAcc);

   always_comb begin
      outValid_d = outValid_q;
      if (rtStart) begin
         outValid_d = 1'b0;
      end else if (ftMode_q & rdAcc) begin
         outValid_d = 1'b1;
      end else if (ftMode_q & outValid_q & rdReq & ~setupBusy) begin
         outValid_d = 1'b0;
      end
   end

   // Output register holds a word in fall-through, so depth grows by one
   assign flagDepth = ftMode_q ? DEPTH_FT : DEPTH_STD;
   assign totLevel_q = memLevel_q + LVL_W'(ftMode_q & outValid_q);
   assign totLevel_d = memLevel_d + LVL_W'(ftMode_q & outValid_d);

   always_comb begin
      rtState_d = rtState_q;
      case (rtState_q)
         FXC_RT_IDLE: begin
            if (rtStart) begin
               rtState_d = FXC_RT_SETUP;
            end
         end
         FXC_RT_SETUP: begin
            rtState_d = FXC_RT_DONE;
         end
         FXC_RT_DONE: begin
            if (retransmitN) begin
               rtState_d = FXC_RT_IDLE;
            end
         end
         default: begin
            rtState_d = FXC_RT_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Strap levels are caught by the clock after release, never by reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfgDone_q <= 1'b0;
         ftMode_q <= 1'b0;
         syncFlags_q <= 1'b0;
      end else if (!cfgDone_q) begin
         cfgDone_q <= 1'b1;
         ftMode_q <= fallThroughMode;
         syncFlags_q <= flagTimingSelect;
      end
   end

   always_ff @(posedge clk) begin
      if (wrAcc) begin
         mem[wrPtr_q] <= writeData;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr_q <= PTR_ZERO;
         rdPtr_q <= PTR_ZERO;
         memLevel_q <= LVL_ZERO;
         outValid_q <= 1'b0;
         rtState_q <= FXC_RT_IDLE;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         memLevel_q <= memLevel_d;
         outValid_q <= outValid_d;
         rtState_q <= rtState_d;
      end
   end

   // Spacing before a mark is the controller's duty and is not checked
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         markHold_q <= 1'b0;
         markPtr_q <= PTR_ZERO;
      end else begin
         markHold_q <= cfgDone_q & markReq;
         if (markRise) begin
            markPtr_q <= rdPtr_q;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         outReg_q <= DATA_ZERO;
      end else if (rdAcc) begin
         outReg_q <= mem[rdPtr_q];
      end
   end
   assign readDataBus = outReg_q;

   // ----------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readDataOeN <= 1'b1;
         emptyIndicator <= 1'b0;
         fullFlag <= 1'b1;
         outputValidFlag <= 1'b1;
         inputReadyFlag <= 1'b1;
         echoedReadEnable <= 1'b1;
      end else begin
         readDataOeN <= ~(~readChipSelectN & ~outputEnableN);
         emptyIndicator <= ~memEmpty & ~setupBusy & ~rtStart;
         fullFlag <= ~(memFull | markBlock);
         outputValidFlag <= ~(ftMode_q & outValid_d);
         inputReadyFlag <= ~ftMode_q | memFull | markBlock;
         if (ftMode_q) begin
            echoedReadEnable <= ~rdAcc;
         end else begin
            echoedReadEnable <= readChipSelectN | readEnableN
               | memEmpty;
         end
      end
   end

   fxc_flag_unit #(
      .FULL_SIDE(1'b1)
   ) u_full_flag (
      .clk(clk),
      .rstn(rstn),
      .syncMode(syncFlags_q),
      .levelQ(totLevel_q),
      .levelD(totLevel_d),
      .offset(almostFullOffset),
      .depth(flagDepth),
      .flagN(almostFullFlag)
   );

   fxc_flag_unit #(
      .FULL_SIDE(1'b0)
   ) u_empty_flag (
      .clk(clk),
      .rstn(rstn),
      .syncMode(syncFlags_q),
      .levelQ(totLevel_q),
      .levelD(totLevel_d),
      .offset(almostEmptyOffset),
      .depth(flagDepth),
      .flagN(almostEmptyFlag)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_FT_FIRST_LOAD: assert property (@(posedge clk) disable iff (!rstn)
      cfgDone_q && ftMode_q && !outValid_q && !memEmpty
      && rtState_q == FXC_RT_IDLE && !rtStart
      |=> !outputValidFlag && !echoedReadEnable)
      else $error("first word did not fall through");

   AST_FT_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      ftMode_q && outValid_q && !rdReq && !rtStart
      |=> $stable(outReg_q) && $stable(rdPtr_q))
      else $error("output word advanced without both enables");

   AST_BUS_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
      (readChipSelectN || outputEnableN) |=> readDataOeN)
      else $error("read bus driven while deselected");

   AST_ECHO_EMPTY: assert property (@(posedge clk) disable iff (!rstn)
      cfgDone_q && !ftMode_q && memEmpty |=> echoedReadEnable)
      else $error("echo enable low while empty");

   AST_FT_LAST: assert property (@(posedge clk) disable iff (!rstn)
      cfgDone_q && ftMode_q && outValid_q && rdReq && memEmpty
      && rtState_q != FXC_RT_SETUP && !rtStart
      |=> outputValidFlag && echoedReadEnable)
      else $error("read past last word not flagged");

   AST_MARK_STOP: assert property (@(posedge clk) disable iff (!rstn)
      markHold_q && markReq && wrPtr_q == markPtr_q |=> $stable(wrPtr_q))
      else $error("write pointer passed the mark");

   AST_RT_SETUP: assert property (@(posedge clk) disable iff (!rstn)
      rtStart && !ftMode_q && rtLevel >= MARK_MIN_WORDS
      |=> !emptyIndicator ##1 !emptyIndicator ##1 emptyIndicator)
      else $error("retransmit setup not closed by empty indicator");

   AST_IR_FREE: assert property (@(posedge clk) disable iff (!rstn)
      ftMode_q && memFull && rdAcc && !markHold_q
      |=> ##1 !inputReadyFlag)
      else $error("input ready not asserted after freeing read");

endmodule

// ### test/fxc_far_writer.sv
`timescale 1ns/1ps
module fxc_far_writer (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Burst request
   input wire logic pushReq,
   input wire logic [7:0] pushLen,
   input wire logic [fxc_pkg::DATA_W-1:0] pushBase,
   // FIFO write port
   output logic writeEnableN,
   output logic [fxc_pkg::DATA_W-1:0] writeData
);
   import fxc_pkg::*;
   logic [7:0] wordsLeft_q;
   logic [DATA_W-1:0] data_q;
   // Idle data is inverted so a stale word never passes for a fresh one
   assign writeEnableN = (wordsLeft_q == 8'h00);
   assign writeData = writeEnableN ? ~data_q : data_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wordsLeft_q <= 8'h00;
         data_q <= DATA_ZERO;
      end else if (pushReq) begin
         wordsLeft_q <= pushLen;
         data_q <= pushBase;
      end else if (wordsLeft_q != 8'h00) begin
         wordsLeft_q <= wordsLeft_q - 8'h01;
         data_q <= data_q + 72'h1;
      end
   end
endmodule

// ### test/fxc_fifo_ctrl_tb.sv
`timescale 1ns/1ps
module fxc_fifo_ctrl_tb;
   import fxc_pkg::*;
   logic clk, rstn, flagTimingSelect, fallThroughMode;
   logic [LVL_W-1:0] almostEmptyOffset, almostFullOffset;
   logic writeEnableN, readChipSelectN, readEnableN, outputEnableN;
   logic markReq, retransmitN, readDataOeN, emptyIndicator, fullFlag;
   logic outputValidFlag, inputReadyFlag, almostFullFlag, almostEmptyFlag;
   logic echoedReadEnable, pushReq;
   logic [DATA_W-1:0] writeData, readDataBus, pushBase;
   logic [7:0] pushLen;
   int numErrors, checked, cycles, echoLows, snap;

   fxc_fifo_ctrl uut (
      .clk, .rstn, .flagTimingSelect, .fallThroughMode, .almostEmptyOffset,
      .almostFullOffset, .writeEnableN, .writeData, .readChipSelectN,
      .readEnableN, .outputEnableN, .markReq, .retransmitN, .readDataBus,
      .readDataOeN, .emptyIndicator, .fullFlag, .outputValidFlag,
      .inputReadyFlag, .almostFullFlag, .almostEmptyFlag, .echoedReadEnable
   );
   fxc_far_writer writer (
      .clk, .rstn, .pushReq, .pushLen, .pushBase, .writeEnableN, .writeData
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard: the longest run is about 33500 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         numErrors++;
         conclude();
      end
   end
   always @(posedge clk) if (rstn && echoedReadEnable === 1'b0) echoLows++;

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [DATA_W-1:0] seen,
                      input logic [DATA_W-1:0] exp);
      checked++;
      if (seen !== exp) begin
         numErrors++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic boot(input logic ft, input logic sync);
      rstn = 1'b0;
      fallThroughMode = ft;
      flagTimingSelect = sync;
      tick(16);
      chk({readDataOeN, emptyIndicator, fullFlag, outputValidFlag,
           inputReadyFlag, almostFullFlag, almostEmptyFlag,
           echoedReadEnable}, 8'hBF);
      chk(readDataBus, DATA_ZERO);
      rstn = 1'b1;
      tick(2);
   endtask
   task automatic push(input int n, input logic [DATA_W-1:0] base);
      pushReq = 1'b1;
      pushLen = n[7:0];
      pushBase = base;
      tick(1);
      pushReq = 1'b0;
      tick(n + 3);
   endtask
   // Leaves the read enabled so reads can run back to back
   task automatic rd(input logic [DATA_W-1:0] exp);
      readEnableN = 1'b0;
      tick(1);
      chk(readDataBus, exp);
      chk(echoedReadEnable, 1'b0);
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      flagTimingSelect = 1'b1;
      fallThroughMode = 1'b0;
      almostEmptyOffset = 15'h0002;
      almostFullOffset = 15'h3FFC;
      readChipSelectN = 1'b0;
      readEnableN = 1'b1;
      outputEnableN = 1'b0;
      markReq = 1'b0;
      retransmitN = 1'b1;
      pushReq = 1'b0;
      pushLen = 8'h00;
      pushBase = DATA_ZERO;
      #1;
      boot(1'b0, 1'b1);
      readEnableN = 1'b0;
      tick(1);
      readEnableN = 1'b1;
      chk(echoedReadEnable, 1'b1);
      push(4, 72'h100);
      chk(emptyIndicator, 1'b1);
      chk(almostFullFlag, 1'b0);
      chk(readDataOeN, 1'b0);
      rd(72'h100);
      readEnableN = 1'b1;
      chk(almostFullFlag, 1'b0);
      tick(1);
      chk(almostFullFlag, 1'b1);
      rd(72'h101);
      rd(72'h102);
      readEnableN = 1'b1;
      tick(2);
      chk(almostEmptyFlag, 1'b0);
      push(2, 72'h103);
      chk(almostEmptyFlag, 1'b1);
      outputEnableN = 1'b1;
      tick(2);
      chk(readDataOeN, 1'b1);
      outputEnableN = 1'b0;
      $display("Standard synchronous flags done");

      boot(1'b0, 1'b0);
      push(3, 72'h200);
      chk(almostEmptyFlag, 1'b1);
      rd(72'h200);
      chk(almostEmptyFlag, 1'b0);
      readEnableN = 1'b1;
      push(2, 72'h203);
      chk(almostFullFlag, 1'b0);
      rd(72'h201);
      chk(almostFullFlag, 1'b1);
      readEnableN = 1'b1;
      $display("Asynchronous flags done");

      readChipSelectN = 1'b1;
      almostFullOffset = 15'h3FFD;
      boot(1'b1, 1'b1);
      chk(inputReadyFlag, 1'b0);
      snap = echoLows;
      push(1, 72'h300);
      chk(outputValidFlag, 1'b0);
      chk(readDataBus, 72'h300);
      chk(readDataOeN, 1'b1);
      chk(DATA_W'(echoLows - snap), 72'h1);
      push(2, 72'h301);
      chk(almostFullFlag, 1'b1);
      push(1, 72'h303);
      chk(almostFullFlag, 1'b0);
      readChipSelectN = 1'b0;
      tick(1);
      chk(readDataOeN, 1'b0);
      rd(72'h301);
      rd(72'h302);
      rd(72'h303);
      tick(1);
      readEnableN = 1'b1;
      tick(1);
      chk(outputValidFlag, 1'b1);
      chk(echoedReadEnable, 1'b1);
      // Fill to the brim: one word in the output register, rest in memory
      for (int i = 0; i < 64; i++) push(255, DATA_ZERO);
      push(65, DATA_ZERO);
      chk(inputReadyFlag, 1'b1);
      rd(72'h1);
      readEnableN = 1'b1;
      tick(1);
      chk(inputReadyFlag, 1'b0);
      $display("Fall-through done");

      almostFullOffset = 15'h3FFC;
      boot(1'b0, 1'b1);
      push(20, 72'h400);
      markReq = 1'b1;
      tick(2);
      rd(72'h400);
      rd(72'h401);
      rd(72'h402);
      readEnableN = 1'b1;
      retransmitN = 1'b0;
      tick(1);
      retransmitN = 1'b1;
      tick(1);
      chk(emptyIndicator, 1'b0);
      tick(1);
      chk(emptyIndicator, 1'b1);
      rd(72'h400);
      rd(72'h401);
      rd(72'h402);
      readEnableN = 1'b1;
      for (int i = 0; i < 64; i++) push(255, DATA_ZERO);
      push(44, DATA_ZERO);
      chk(fullFlag, 1'b0);
      push(1, 72'h5A5);
      rd(72'h403);
      readEnableN = 1'b1;
      tick(3);
      chk(fullFlag, 1'b0);
      markReq = 1'b0;
      tick(3);
      chk(fullFlag, 1'b1);
      $display("Mark and retransmit done");
      conclude();
   end
endmodule
